// ---- verilog/sml_pkg.sv ----
// shared constants for the mode register and latency setup block
package sml_pkg;
    // mode register select codes on the bank lines
    localparam logic [2:0] SEL_MODE_ONE = 3'h1;
    localparam logic [2:0] SEL_MODE_TWO = 3'h2;
    localparam logic [2:0] SEL_MODE_FIVE = 3'h5;
    localparam int ADDR_W = 14;

    // field positions inside the mode registers
    localparam int OUT_OFF_BIT = 12;
    localparam int DRV_LO = 1;
    localparam int DRV_HI = 2;
    localparam int NOM_LO = 8;
    localparam int NOM_HI = 10;
    localparam int WRT_LO = 9;
    localparam int WRT_HI = 10;
    localparam int SRR_LO = 6;
    localparam int SRR_HI = 7;
    localparam int PARK_LO = 6;
    localparam int PARK_HI = 8;

    // field codes and the divisor of the calibration resistor they pick
    localparam logic [1:0] DRV_CODE_SEVENTH = 2'h0;
    localparam logic [2:0] NOM_CODE_SIXTH = 3'h3;
    localparam logic [1:0] WRT_CODE_HALF = 2'h1;
    localparam logic [2:0] PARK_CODE_OFF = 3'h0;
    localparam logic [3:0] DIV_SEVEN = 4'h7;
    localparam logic [3:0] DIV_SIX = 4'h6;
    localparam logic [3:0] DIV_TWO = 4'h2;
    localparam logic [3:0] DIV_NONE = 4'h0;

    typedef enum logic [1:0] {
        SRR_NORMAL = 2'h0,
        SRR_REDUCED = 2'h1,
        SRR_EXTENDED = 2'h2,
        SRR_AUTO = 2'h3
    } sml_srr_t;

    // register byte addresses
    localparam logic [7:0] REG_CFG = 8'h00;
    localparam logic [7:0] REG_TIMING = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_MODE_ONE = 8'h0C;
    localparam logic [7:0] REG_MODE_TWO = 8'h10;
    localparam logic [7:0] REG_MODE_FIVE = 8'h14;
    localparam logic [31:0] CFG_RESET = 32'h0000_0001;
    localparam logic [31:0] TIMING_RESET = 32'h0000_0000;
    localparam int CFG_DLL_ON_BIT = 0;
    localparam int CFG_HALF_RATE_BIT = 1;
    localparam int TIM_TCK_LO = 0;
    localparam int TIM_TCK_HI = 15;
    localparam int TIM_RL_LO = 16;
    localparam int TIM_RL_HI = 20;
    localparam int TIM_WL_LO = 24;
    localparam int TIM_WL_HI = 28;
    localparam int ST_COMBO_BIT = 0;
    localparam int ST_RATED_BIT = 1;
    localparam int ST_DLL_OFF_OK_BIT = 2;
    localparam int ST_SPACING_BIT = 3;
    localparam int ST_UPDATED_BIT = 4;

    // clock period bounds in ps: a minimum per latency row, a maximum for row 0 only, then the loop-off window
    localparam logic [15:0] ROW0_MIN_PS = 16'h05DC;
    localparam logic [15:0] ROW0_MAX_PS = 16'h0640;
    localparam logic [15:0] ROW1_MIN_PS = 16'h04E2;
    localparam logic [15:0] ROW2_MIN_PS = 16'h042F;
    localparam logic [15:0] ROW3_MIN_PS = 16'h03A9;
    localparam logic [15:0] ROW4_MIN_PS = 16'h0341;
    localparam logic [15:0] DLL_OFF_MIN_PS = 16'h1F40;
    localparam logic [15:0] DLL_OFF_MAX_PS = 16'h4E20;

    // least spacing of mode set commands, in link clock cycles
    localparam logic [3:0] MODE_SET_SPACING_CYC = 4'h8;
endpackage

// ---- verilog/sml_word_cdc.sv ----
// toggle handshake carrying one word from one clock domain to another
`timescale 1ns/1ps
module sml_word_cdc #(
    parameter int W = 42
) (
    // source side
    input wire logic src_clk,
    input wire logic src_rst,
    input wire logic src_load,
    input wire logic [W-1:0] src_data,
    output logic src_busy,
    // destination side
    input wire logic dst_clk,
    input wire logic dst_rst,
    output logic dst_valid,
    output logic [W-1:0] dst_data
);
    if (W < 1) begin : g_bad_w
        $error("sml_word_cdc: W must be positive");
    end

    logic req, next_req;
    logic [W-1:0] hold, next_hold;
    logic ack_m, ack_s;
    logic req_m, req_s, req_seen;
    logic ack, next_valid;
    logic [W-1:0] next_dst_data;

    // hold is frozen while busy, so the far side samples a still word
    always_comb begin
        next_req = req;
        next_hold = hold;
        if (src_load && !src_busy) begin
            next_req = ~req;
            next_hold = src_data;
        end
    end

    always_ff @(posedge src_clk or posedge src_rst) begin
        if (src_rst) begin
            req <= 1'b0;
            hold <= '0;
            ack_m <= 1'b0;
            ack_s <= 1'b0;
        end else begin
            req <= next_req;
            hold <= next_hold;
            ack_m <= ack;
            ack_s <= ack_m;
        end
    end

    assign src_busy = req ^ ack_s;

    always_comb begin
        next_valid = req_s ^ req_seen;
        next_dst_data = dst_data;
        if (req_s ^ req_seen) begin
            next_dst_data = hold;
        end
    end

    always_ff @(posedge dst_clk or posedge dst_rst) begin
        if (dst_rst) begin
            req_m <= 1'b0;
            req_s <= 1'b0;
            req_seen <= 1'b0;
            dst_valid <= 1'b0;
            dst_data <= '0;
        end else begin
            req_m <= req;
            req_s <= req_m;
            req_seen <= req_s;
            dst_valid <= next_valid;
            dst_data <= next_dst_data;
        end
    end

    assign ack = req_seen;
endmodule // sml_word_cdc

// ---- verilog/sml_mode_setup.sv ----
// mode register decode, mode set spacing watch and latency legality check
// Functional notes
// - output buffers on when A12 of register one low
// - drive code 00 selects resistor over seven
// - nominal code 011 selects resistor over six
// - write code 01 selects resistor over two
// - park code 000 turns park termination off
// - self refresh range field decodes four ranges
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module sml_mode_setup (
    // system clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // command link from the controller
    input wire logic link_clk,
    input wire logic mode_set,
    input wire logic [2:0] mode_sel,
    input wire logic [sml_pkg::ADDR_W-1:0] mode_addr,
    // decoded controls, link clock domain
    output logic out_buf_en,
    output logic [3:0] drive_impedance_div,
    output logic [3:0] nominal_termination_div,
    output logic [3:0] write_termination_div,
    output logic park_termination,
    output logic [1:0] self_refresh_range_field
);
    localparam int AW = sml_pkg::ADDR_W;
    localparam int IMG_W = 3 * AW;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_WAIT = 2'b10
    } sml_tx_t;

    // link domain reset: asserted at once, released on the link clock
    logic lrst_m, lrst;
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            lrst_m <= 1'b1;
            lrst <= 1'b1;
        end else begin
            lrst_m <= 1'b0;
            lrst <= lrst_m;
        end
    end

    // ---------------- link domain ----------------
    logic [AW-1:0] mode_one, mode_two, mode_five;
    logic [AW-1:0] next_mode_one, next_mode_two, next_mode_five;
    logic [3:0] gap_cnt, next_gap_cnt;
    logic gap_err_tgl, next_gap_err_tgl;
    logic pending, next_pending;
    sml_tx_t tx_state, next_tx_state;
    logic tx_load, tx_busy;
    logic next_out_buf_en, next_park;
    logic [3:0] next_drv_div, next_nom_div, next_wrt_div;
    logic [1:0] next_srr;
    sml_pkg::sml_srr_t srr_dec;

    always_comb begin
        next_mode_one = mode_one;
        next_mode_two = mode_two;
        next_mode_five = mode_five;
        next_gap_err_tgl = gap_err_tgl;
        next_gap_cnt = gap_cnt;
        if (gap_cnt < sml_pkg::MODE_SET_SPACING_CYC) begin
            next_gap_cnt = gap_cnt + 4'h1;
        end
        if (mode_set) begin
            case (mode_sel)
                sml_pkg::SEL_MODE_ONE: next_mode_one = mode_addr;
                sml_pkg::SEL_MODE_TWO: next_mode_two = mode_addr;
                sml_pkg::SEL_MODE_FIVE: next_mode_five = mode_addr;
                default: next_mode_one = mode_one;
            endcase
            // too close to the previous set: flag it, still accept it
            if (gap_cnt < sml_pkg::MODE_SET_SPACING_CYC) begin
                next_gap_err_tgl = ~gap_err_tgl;
            end
            next_gap_cnt = 4'h1;
        end
    end

    // decode of the stored images into the analog controls
    always_comb begin
        next_out_buf_en = ~mode_one[sml_pkg::OUT_OFF_BIT];
        next_drv_div = sml_pkg::DIV_NONE;
        if (mode_one[sml_pkg::DRV_HI:sml_pkg::DRV_LO]
                == sml_pkg::DRV_CODE_SEVENTH) begin
            next_drv_div = sml_pkg::DIV_SEVEN;
        end
        next_nom_div = sml_pkg::DIV_NONE;
        if (mode_one[sml_pkg::NOM_HI:sml_pkg::NOM_LO]
                == sml_pkg::NOM_CODE_SIXTH) begin
            next_nom_div = sml_pkg::DIV_SIX;
        end
        next_wrt_div = sml_pkg::DIV_NONE;
        if (mode_two[sml_pkg::WRT_HI:sml_pkg::WRT_LO]
                == sml_pkg::WRT_CODE_HALF) begin
            next_wrt_div = sml_pkg::DIV_TWO;
        end
        next_park = mode_five[sml_pkg::PARK_HI:sml_pkg::PARK_LO]
            != sml_pkg::PARK_CODE_OFF;
        case (mode_two[sml_pkg::SRR_HI:sml_pkg::SRR_LO])
            2'h0: srr_dec = sml_pkg::SRR_NORMAL;
            2'h1: srr_dec = sml_pkg::SRR_REDUCED;
            2'h2: srr_dec = sml_pkg::SRR_EXTENDED;
            default: srr_dec = sml_pkg::SRR_AUTO;
        endcase
        next_srr = srr_dec;
    end

    // a newer set while a word is in flight is sent right after it
    always_comb begin
        next_tx_state = tx_state;
        next_pending = pending | mode_set;
        tx_load = 1'b0;
        case (tx_state)
            TX_IDLE: begin
                if (pending) begin
                    tx_load = 1'b1;
                    next_pending = mode_set;
                    next_tx_state = TX_WAIT;
                end
            end
            TX_WAIT: begin
                if (!tx_busy) begin
                    next_tx_state = TX_IDLE;
                end
            end
            default: next_tx_state = TX_IDLE;
        endcase
    end

    always_ff @(posedge link_clk or posedge lrst) begin
        if (lrst) begin
            mode_one <= '0;
            mode_two <= '0;
            mode_five <= '0;
            gap_cnt <= sml_pkg::MODE_SET_SPACING_CYC;
            gap_err_tgl <= 1'b0;
            pending <= 1'b0;
            tx_state <= TX_IDLE;
            out_buf_en <= 1'b1;
            drive_impedance_div <= sml_pkg::DIV_SEVEN;
            nominal_termination_div <= sml_pkg::DIV_NONE;
            write_termination_div <= sml_pkg::DIV_NONE;
            park_termination <= 1'b0;
            self_refresh_range_field <= sml_pkg::SRR_NORMAL;
        end else begin
            mode_one <= next_mode_one;
            mode_two <= next_mode_two;
            mode_five <= next_mode_five;
            gap_cnt <= next_gap_cnt;
            gap_err_tgl <= next_gap_err_tgl;
            pending <= next_pending;
            tx_state <= next_tx_state;
            out_buf_en <= next_out_buf_en;
            drive_impedance_div <= next_drv_div;
            nominal_termination_div <= next_nom_div;
            write_termination_div <= next_wrt_div;
            park_termination <= next_park;
            self_refresh_range_field <= next_srr;
        end
    end

    // ---------------- crossing ----------------
    logic img_valid;
    logic [IMG_W-1:0] img_data;

    sml_word_cdc #(
        .W(IMG_W)
    ) u_img_cdc (
        .src_clk(link_clk),
        .src_rst(lrst),
        .src_load(tx_load),
        .src_data({mode_five, mode_two, mode_one}),
        .src_busy(tx_busy),
        .dst_clk(clk),
        .dst_rst(rst),
        .dst_valid(img_valid),
        .dst_data(img_data)
    );

    logic err_m, err_s, err_seen;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            err_m <= 1'b0;
            err_s <= 1'b0;
            err_seen <= 1'b0;
        end else begin
            err_m <= gap_err_tgl;
            err_s <= err_m;
            err_seen <= err_s;
        end
    end

    // ---------------- system domain ----------------
    // legal when the row of the read latency holds the write latency
    // and the period lies in that row; reserved pairs fall through
    function automatic logic combo_ok(input logic [4:0] rl,
            input logic [4:0] wl, input logic [15:0] tck);
        logic ok;
        ok = 1'b0;
        case (rl)
            5'h0A: ok = (wl == 5'h09) && tck >= sml_pkg::ROW0_MIN_PS
                && tck <= sml_pkg::ROW0_MAX_PS;
            5'h0B, 5'h0C: ok = (wl == 5'h09 || wl == 5'h0B)
                && tck >= sml_pkg::ROW1_MIN_PS
                && tck < sml_pkg::ROW0_MIN_PS;
            5'h0D, 5'h0E: ok = (wl == 5'h0A || wl == 5'h0C)
                && tck >= sml_pkg::ROW2_MIN_PS
                && tck < sml_pkg::ROW1_MIN_PS;
            5'h0F, 5'h10: ok = (wl == 5'h0B || wl == 5'h0E)
                && tck >= sml_pkg::ROW3_MIN_PS
                && tck < sml_pkg::ROW2_MIN_PS;
            5'h11, 5'h12: ok = (wl == 5'h0C || wl == 5'h10)
                && tck >= sml_pkg::ROW4_MIN_PS
                && tck < sml_pkg::ROW3_MIN_PS;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    logic [31:0] cfg, next_cfg, timing, next_timing;
    logic [AW-1:0] sw_one, sw_two, sw_five;
    logic [AW-1:0] next_sw_one, next_sw_two, next_sw_five;
    logic spacing_err, next_spacing_err;
    logic updated, next_updated;
    logic st_combo, st_rated, st_dll_off_ok;
    logic next_combo, next_rated, next_dll_off_ok;
    logic [31:0] next_rdata, status;
    logic [15:0] tck_ps;
    logic clr_status;

    assign tck_ps = timing[sml_pkg::TIM_TCK_HI:sml_pkg::TIM_TCK_LO];
    assign clr_status = reg_wr && reg_addr == sml_pkg::REG_STATUS;

    always_comb begin
        next_cfg = cfg;
        next_timing = timing;
        if (reg_wr && reg_addr == sml_pkg::REG_CFG) begin
            next_cfg = reg_wdata;
        end
        if (reg_wr && reg_addr == sml_pkg::REG_TIMING) begin
            next_timing = reg_wdata;
        end
        next_sw_one = sw_one;
        next_sw_two = sw_two;
        next_sw_five = sw_five;
        if (img_valid) begin
            next_sw_one = img_data[AW-1:0];
            next_sw_two = img_data[2*AW-1:AW];
            next_sw_five = img_data[3*AW-1:2*AW];
        end
        // write one clears; a new event in the same cycle wins
        next_spacing_err = spacing_err;
        if (clr_status && reg_wdata[sml_pkg::ST_SPACING_BIT]) begin
            next_spacing_err = 1'b0;
        end
        if (err_s ^ err_seen) begin
            next_spacing_err = 1'b1;
        end
        next_updated = updated;
        if (clr_status && reg_wdata[sml_pkg::ST_UPDATED_BIT]) begin
            next_updated = 1'b0;
        end
        if (img_valid) begin
            next_updated = 1'b1;
        end
        // table bounds are the binned-down longest periods
        next_combo = combo_ok(timing[sml_pkg::TIM_RL_HI:sml_pkg::TIM_RL_LO],
            timing[sml_pkg::TIM_WL_HI:sml_pkg::TIM_WL_LO],
            tck_ps);
        next_rated = cfg[sml_pkg::CFG_DLL_ON_BIT]
            && !cfg[sml_pkg::CFG_HALF_RATE_BIT];
        next_dll_off_ok = !cfg[sml_pkg::CFG_DLL_ON_BIT]
            && tck_ps >= sml_pkg::DLL_OFF_MIN_PS
            && tck_ps <= sml_pkg::DLL_OFF_MAX_PS;
    end

    always_comb begin
        status = '0;
        status[sml_pkg::ST_COMBO_BIT] = st_combo;
        status[sml_pkg::ST_RATED_BIT] = st_rated;
        status[sml_pkg::ST_DLL_OFF_OK_BIT] = st_dll_off_ok;
        status[sml_pkg::ST_SPACING_BIT] = spacing_err;
        status[sml_pkg::ST_UPDATED_BIT] = updated;
        next_rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                sml_pkg::REG_CFG: next_rdata = cfg;
                sml_pkg::REG_TIMING: next_rdata = timing;
                sml_pkg::REG_STATUS: next_rdata = status;
                sml_pkg::REG_MODE_ONE: next_rdata = {18'h0, sw_one};
                sml_pkg::REG_MODE_TWO: next_rdata = {18'h0, sw_two};
                sml_pkg::REG_MODE_FIVE: next_rdata = {18'h0, sw_five};
                default: next_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg <= sml_pkg::CFG_RESET;
            timing <= sml_pkg::TIMING_RESET;
            sw_one <= '0;
            sw_two <= '0;
            sw_five <= '0;
            spacing_err <= 1'b0;
            updated <= 1'b0;
            st_combo <= 1'b0;
            st_rated <= 1'b0;
            st_dll_off_ok <= 1'b0;
            reg_rdata <= '0;
        end else begin
            cfg <= next_cfg;
            timing <= next_timing;
            sw_one <= next_sw_one;
            sw_two <= next_sw_two;
            sw_five <= next_sw_five;
            spacing_err <= next_spacing_err;
            updated <= next_updated;
            st_combo <= next_combo;
            st_rated <= next_rated;
            st_dll_off_ok <= next_dll_off_ok;
            reg_rdata <= next_rdata;
        end
    end
endmodule // sml_mode_setup

// ---- verif/sml_mode_setup_chk.sv ----
// assertion checker for the decoded mode register controls
`timescale 1ns/1ps
module sml_mode_setup_chk (
    // link side inputs
    input wire logic link_clk,
    input wire logic rst,
    input wire logic mode_set,
    input wire logic [2:0] mode_sel,
    input wire logic [sml_pkg::ADDR_W-1:0] mode_addr,
    // decoded controls
    input wire logic out_buf_en,
    input wire logic [3:0] drive_impedance_div,
    input wire logic [3:0] nominal_termination_div,
    input wire logic [3:0] write_termination_div,
    input wire logic park_termination,
    input wire logic [1:0] self_refresh_range_field
);
    default clocking cb @(posedge link_clk);
    endclocking
    default disable iff (rst);

    property p_buf_on;
        mode_set && mode_sel == sml_pkg::SEL_MODE_ONE |-> ##2
            out_buf_en == !$past(mode_addr[12], 2);
    endproperty
    a_buf_on: assert property (p_buf_on)
        else $error("output buffer enable wrong");
    property p_drive;
        mode_set && mode_sel == sml_pkg::SEL_MODE_ONE |-> ##2
            drive_impedance_div ==
            (($past(mode_addr[2:1], 2) == 2'h0) ? 4'h7 : 4'h0);
    endproperty
    a_drive: assert property (p_drive)
        else $error("drive impedance wrong");
    property p_nom;
        mode_set && mode_sel == sml_pkg::SEL_MODE_ONE |-> ##2
            nominal_termination_div ==
            (($past(mode_addr[10:8], 2) == 3'h3) ? 4'h6 : 4'h0);
    endproperty
    a_nom: assert property (p_nom)
        else $error("nominal termination wrong");
    property p_wrt;
        mode_set && mode_sel == sml_pkg::SEL_MODE_TWO |-> ##2
            write_termination_div ==
            (($past(mode_addr[10:9], 2) == 2'h1) ? 4'h2 : 4'h0);
    endproperty
    a_wrt: assert property (p_wrt)
        else $error("write termination wrong");
    property p_park;
        mode_set && mode_sel == sml_pkg::SEL_MODE_FIVE |-> ##2
            park_termination == ($past(mode_addr[8:6], 2) != 3'h0);
    endproperty
    a_park: assert property (p_park)
        else $error("park termination wrong");
    property p_srr;
        mode_set && mode_sel == sml_pkg::SEL_MODE_TWO |-> ##2
            self_refresh_range_field == $past(mode_addr[7:6], 2);
    endproperty
    a_srr: assert property (p_srr)
        else $error("self refresh range wrong");
    // controls may only move as a result of a mode set
    property p_hold;
        !mode_set [*3] |=> $stable({out_buf_en, drive_impedance_div,
            nominal_termination_div, write_termination_div,
            park_termination, self_refresh_range_field});
    endproperty
    a_hold: assert property (p_hold)
        else $error("controls moved without a mode set");
endmodule // sml_mode_setup_chk

bind sml_mode_setup sml_mode_setup_chk u_chk (
    .link_clk(link_clk),
    .rst(rst),
    .mode_set(mode_set),
    .mode_sel(mode_sel),
    .mode_addr(mode_addr),
    .out_buf_en(out_buf_en),
    .drive_impedance_div(drive_impedance_div),
    .nominal_termination_div(nominal_termination_div),
    .write_termination_div(write_termination_div),
    .park_termination(park_termination),
    .self_refresh_range_field(self_refresh_range_field)
);

// ---- verif/sml_ctrl_model.sv ----
// controller model issuing mode register set commands on the link clock
`timescale 1ns/1ps
module sml_ctrl_model (
    // link clock
    input wire logic link_clk,
    // command outputs
    output logic mode_set,
    output logic [2:0] mode_sel,
    output logic [sml_pkg::ADDR_W-1:0] mode_addr
);
    initial begin
        mode_set = 1'b0;
        mode_sel = 3'h0;
        mode_addr = '0;
    end

    // short_gap breaks the command spacing on purpose after this command
    task automatic send(input logic [2:0] sel,
            input logic [sml_pkg::ADDR_W-1:0] addr, input bit short_gap);
        @(posedge link_clk);
        mode_set <= 1'b1;
        mode_sel <= sel;
        mode_addr <= addr;
        @(posedge link_clk);
        mode_set <= 1'b0;
        // released lines show the inverse so stale values never match
        mode_sel <= ~sel;
        mode_addr <= ~addr;
        if (!short_gap)
            repeat (6) @(posedge link_clk);
    endtask
endmodule // sml_ctrl_model

// ---- verif/testbench.sv ----
// self-checking bench for the mode register and latency setup block
`timescale 1ns/1ps
module testbench;
    logic clk, link_clk, rst, reg_wr, reg_rd;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic mode_set, obe, park;
    logic [2:0] mode_sel;
    logic [sml_pkg::ADDR_W-1:0] mode_addr;
    logic [3:0] drv, nom, wrt;
    logic [1:0] srr;
    int mismatches, comparisons, cycles, m1, m2, m5;
    int tr[18] = '{10,10,10,10,11,12,12,13,14,14,15,16,16,17,18,18,9,12};
    int tw[18] = '{9,9,9,9,11,9,9,10,12,12,14,11,11,16,12,12,9,10};
    int tt[18] = '{1500,1600,1601,1499,1250,1499,1500,1071,1249,1070,
                   937,1070,1071,833,936,832,1500,1300};
    int tk[5] = '{1500,7999,8000,20000,20001};

    sml_mode_setup DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .link_clk(link_clk), .mode_set(mode_set),
        .mode_sel(mode_sel), .mode_addr(mode_addr), .out_buf_en(obe),
        .drive_impedance_div(drv), .nominal_termination_div(nom),
        .write_termination_div(wrt), .park_termination(park),
        .self_refresh_range_field(srr));
    sml_ctrl_model ctrl (.link_clk(link_clk), .mode_set(mode_set),
        .mode_sel(mode_sel), .mode_addr(mode_addr));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        link_clk = 1'b0;
        #1.7;
        forever #3 link_clk = ~link_clk;
    end

    task automatic close_out();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            mismatches++;
            close_out();
        end
    end

    task automatic chk_reg(string what, logic [31:0] e, logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic chk_pin(string what, logic [3:0] e, logic [3:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask
    task automatic set_mode(logic [2:0] s, logic [13:0] a, bit short_gap);
        ctrl.send(s, a, short_gap);
        if (s == 3'h1) m1 = int'(a);
        if (s == 3'h2) m2 = int'(a);
        if (s == 3'h5) m5 = int'(a);
    endtask
    task automatic check_outs();
        chk_pin("out_buf_en", {3'h0, !m1[12]}, {3'h0, obe});
        chk_pin("drive", (m1[2:1] == 2'h0) ? 4'h7 : 4'h0, drv);
        chk_pin("nominal", (m1[10:8] == 3'h3) ? 4'h6 : 4'h0, nom);
        chk_pin("write", (m2[10:9] == 2'h1) ? 4'h2 : 4'h0, wrt);
        chk_pin("park", {3'h0, m5[8:6] != 3'h0}, {3'h0, park});
        chk_pin("srr", {2'h0, m2[7:6]}, {2'h0, srr});
    endtask
    function automatic bit legal(int rl, int wl, int t);
        case (rl)
            10: return wl == 9 && t >= 1500 && t <= 1600;
            11, 12: return (wl == 9 || wl == 11) && t >= 1250 && t < 1500;
            13, 14: return (wl == 10 || wl == 12) && t >= 1071 && t < 1250;
            15, 16: return (wl == 11 || wl == 14) && t >= 937 && t < 1071;
            17, 18: return (wl == 12 || wl == 16) && t >= 833 && t < 937;
            default: return 1'b0;
        endcase
    endfunction

    initial begin
        logic [31:0] d;
        logic [2:0] sel;
        logic [13:0] a;
        int rl, wl, t, e;
        bit dok;
        {mismatches, comparisons, cycles, m1, m2, m5} = '0;
        rst = 1'b1;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        void'($urandom(71));
        repeat (10) @(posedge clk);
        check_outs();
        rst <= 1'b0;
        rd(8'h00, d);
        chk_reg("cfg reset", 32'h1, d);
        rd(8'h04, d);
        chk_reg("timing reset", 32'h0, d);
        // each field's special code and all four range codes, with specials on alternate rounds
        for (int i = 0; i < 12; i++) begin
            sel = (i % 3 == 0) ? 3'h1 : (i % 3 == 1) ? 3'h2 : 3'h5;
            a = 14'($urandom);
            if ((i / 3) % 2 == 0)
                a = (sel == 3'h5) ? a & ~14'h01C0 : (a & ~14'h1706) | 14'h0300;
            if (sel == 3'h2)
                a[7:6] = 2'(i / 3);
            set_mode(sel, a, 1'b0);
            check_outs();
            repeat (10) @(posedge clk);
            rd((sel == 3'h1) ? 8'h0C : (sel == 3'h2) ? 8'h10 : 8'h14, d);
            chk_reg("image", {18'h0, a}, d);
        end
        set_mode(3'h3, 14'h3FFF, 1'b0);
        check_outs();
        // spacing: short gap flags, gap of eight does not
        wr(8'h08, 32'h18);
        set_mode(3'h1, 14'h1000, 1'b1);
        set_mode(3'h5, 14'h0040, 1'b0);
        check_outs();
        repeat (10) @(posedge clk);
        rd(8'h08, d);
        chk_reg("spacing flag", 32'h3, {30'h0, d[4:3]});
        wr(8'h08, 32'h8);
        rd(8'h08, d);
        chk_reg("spacing clear", 32'h0, {31'h0, d[3]});
        set_mode(3'h1, 14'h0306, 1'b0);
        set_mode(3'h2, 14'h02C0, 1'b0);
        check_outs();
        repeat (10) @(posedge clk);
        rd(8'h08, d);
        chk_reg("spacing ok", 32'h0, {31'h0, d[3]});
        // latency pairs against period, boundaries then random
        wr(8'h00, 32'h1);
        for (int i = 0; i < 40; i++) begin
            rl = (i < 18) ? tr[i] : 9 + $urandom % 11;
            wl = (i < 18) ? tw[i] : 8 + $urandom % 10;
            t = (i < 18) ? tt[i] : 800 + $urandom % 900;
            wr(8'h04, {3'h0, wl[4:0], 3'h0, rl[4:0], t[15:0]});
            rd(8'h08, d);
            e = {31'h0, legal(rl, wl, t)};
            chk_reg("pair", e, {31'h0, d[0]});
        end
        // rated mode and loop-off period window
        for (int c = 0; c < 4; c++) begin
            wr(8'h00, 32'(c));
            for (int k = 0; k < 5; k++) begin
                wr(8'h04, 32'h090A_0000 | 32'(tk[k]));
                rd(8'h08, d);
                dok = c % 2 == 0 && tk[k] >= 8000 && tk[k] <= 20000;
                e = {30'h0, dok, c == 1};
                chk_reg("rated", e, {30'h0, d[2:1]});
            end
        end
        wr(8'h20, 32'hFFFF_FFFF);
        rd(8'h20, d);
        chk_reg("unmapped", 32'h0, d);
        wr(8'h0C, 32'h0);
        rd(8'h0C, d);
        chk_reg("image ro", {18'h0, m1[13:0]}, d);
        close_out();
    end
endmodule // testbench
